// [lsa_frame_addressing.sv]
// lsa_frame_addressing: frame classification and node addressing of a lin slave
//
// Summary of operation
// [R1] address from programmed bits and strap bits
// [R2] full compare, short position four bits
// [R3] frames carry 2, 4 or 8 bytes
// [R4] master sets bit 7 for application commands
// [R5] reserved frame byte 0x00 means sleep
// [R6] general purpose: command, flag+address, parameters
// [R7] flag one needs match, zero all nodes
// [R8] application identifier executes without address check
// [R9] node bound identifier acted on by that node
// [R10] reserved frame: marker, command, address, parameters
// [R11] one addressed slave answers a read header
// [R12] direct read identifier only triggers its read
// [R13] indirect read needs preceding matching preparation
// [R14] every answer carries own node address
// [R15] direct read answers without preparation
// [R16] 0x3d read answers the prepared command
// [R17] preparation stores command and match
// [R18] short preparation: flagged command, flagged address
// [R19] long preparation: marker, command, address, data
// [R20] byte 2 is command only after 0x80
// [R21] identifier parity bits, bit 5 zero
// [R22] six id bits, two parity bits
// [R23] address mapping is a design parameter
// [R24] mismatch ignored, preparation cleared next frame
`timescale 1ns/100ps

module lsa_frame_addressing
    import lsa_pkg::*;
#(
    parameter logic [20:0] MAP_FOR_SEL0 = MAP_SEL0,
    parameter logic [20:0] MAP_FOR_SEL1 = MAP_SEL1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire lsa_apb_type apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] programmed_address_bits,
    input wire logic address_mapping_select,
    input wire logic [2:0] strap_address_bits,
    input wire logic hdrValid,
    input wire logic [7:0] hdrPid,
    input wire logic frameValid,
    input wire lsa_frame_type frameIn,
    output lsa_cmd_type cmdOut,
    output logic sleepReq,
    output lsa_resp_type respOut,
    output logic [6:0] nodeAddr
);

    typedef struct packed {
        logic [2:0] strapS1;
        logic [2:0] strapS2;
        logic [2:0] strapS3;
        logic [2:0] strapStable;
        logic enable;
        logic [NUM_PTR-1:0][5:0] dynId;
        lsa_prep_type prep;
        logic [6:0] prepCmd;
        logic prepMatch;
        logic parErr;
        lsa_cmd_type cmd;
        logic sleep;
        lsa_resp_type resp;
        logic [31:0] rdata;
        logic slvErr;
    } lsa_state_type;

    lsa_state_type st_reg;
    lsa_state_type st_next;

    function automatic logic [7:0] byteOf(input logic [63:0] d, input int n);
        byteOf = d[8*(n-1) +: 8];
    endfunction : byteOf

    // lin identifier parity over the six id bits
    function automatic logic [7:0] protect(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        protect = {p1, p0, id};
    endfunction : protect

    function automatic logic [3:0] lenOf(input logic [5:0] id);
        case (id[5:4])
            2'b10: lenOf = LEN_4;
            2'b11: lenOf = LEN_8;
            default: lenOf = LEN_2;
        endcase
    endfunction : lenOf

    // zero the bytes a short frame never carried
    function automatic logic [63:0] trim(input logic [63:0] d, input logic [3:0] len);
        logic [63:0] m;
        m = '1;
        if (len == LEN_2) begin
            m = 64'h0000_0000_0000_ffff;
        end else if (len == LEN_4) begin
            m = 64'h0000_0000_ffff_ffff;
        end
        trim = d & m;
    endfunction : trim

    function automatic logic addrHit(input logic [6:0] a, input logic [6:0] own,
                                     input logic [6:0] cmd);
        logic [6:0] m;
        m = MASK_FULL;
        if (cmd >= CMD_SHORT_FIRST && cmd <= CMD_SHORT_LAST) begin
            m = MASK_SHORT; // [R2]
        end
        addrHit = ((a ^ own) & m) == 7'h00; // [R2]
    endfunction : addrHit

    function automatic logic [6:0] mapAddr(input logic [3:0] pa, input logic [2:0] hw,
                                           input logic [20:0] map);
        logic [6:0] src;
        src = {pa, hw};
        for (int i = 0; i < 7; i++) begin
            mapAddr[i] = src[map[3*i +: 3]]; // [R1]
        end
    endfunction : mapAddr

    function automatic lsa_cmd_type mkCmd(input logic [6:0] code, input int ptr,
                                          input logic [47:0] params);
        mkCmd.valid = 1'b1;
        mkCmd.code = code;
        mkCmd.ptr = ptr[3:0];
        mkCmd.params = params;
    endfunction : mkCmd

    logic [6:0] ownAddr;

    // otp bits are static, so they need no synchroniser
    assign ownAddr = mapAddr(programmed_address_bits, st_reg.strapStable,
                             address_mapping_select ? MAP_FOR_SEL1 : MAP_FOR_SEL0); // [R1] [R23]

    always_comb begin
        lsa_state_type n;
        logic [5:0] id;
        logic [63:0] d;
        logic [7:0] cmd;
        logic [7:0] adr;
        logic isDirect;
        logic isApp;
        logic [31:0] rd;
        logic hit;
        logic parEvt;
        n = st_reg;
        id = frameIn.pid[5:0];
        d = trim(frameIn.data, lenOf(id)); // [R3]
        cmd = 8'h00;
        adr = 8'h00;
        parEvt = 1'b0;
        isDirect = 1'b0;
        isApp = 1'b0;
        rd = 32'h0000_0000;
        hit = 1'b1;
        n.cmd.valid = 1'b0;
        n.sleep = 1'b0;
        n.resp.valid = 1'b0;

        // strap pins: three stages, accept once stages two and three agree
        n.strapS1 = strap_address_bits;
        n.strapS2 = st_reg.strapS1;
        n.strapS3 = st_reg.strapS2;
        if (st_reg.strapS2 == st_reg.strapS3) begin
            n.strapStable = st_reg.strapS3;
        end

        // writing and preparing frames, data already received
        if (frameValid && st_reg.enable) begin
            for (int p = 0; p < NUM_PTR; p++) begin
                if (id == st_reg.dynId[p] && (p == PTR_GET_POS || p == PTR_GET_STATUS)) begin
                    isDirect = 1'b1;
                end
                if (id == st_reg.dynId[p] && p >= PTR_APP_FIRST && p <= PTR_APP_LAST) begin
                    isApp = 1'b1;
                end
            end
            if (frameIn.pid != protect(id)) begin
                parEvt = 1'b1;
                n.parErr = 1'b1; // [R22]
            end else if (id == ID_EXTENDED) begin
                n.cmd.valid = 1'b0; // [R22]
            end else if (id == ID_CMD) begin
                cmd = byteOf(d, 2);
                adr = byteOf(d, 3);
                if (byteOf(d, 1) == BYTE_SLEEP) begin
                    n.sleep = 1'b1; // [R5]
                end else if (byteOf(d, 1) == BYTE_EXT) begin // [R20] [R4]
                    hit = !adr[7] || addrHit(adr[6:0], ownAddr, cmd[6:0]); // [R7] [R24]
                    if (cmd[7] && cmd[6:0] <= CMD_READ_LAST) begin
                        n.prep = PREP_HELD; // [R19] [R17]
                        n.prepCmd = cmd[6:0];
                        n.prepMatch = adr[7] && hit;
                    end else if (hit) begin
                        n.cmd = mkCmd(cmd[6:0], PTR_PREP + 1, {d[63:32], 16'h0000}); // [R10]
                    end
                end
            end else if (isDirect) begin
                n.cmd.valid = 1'b0; // [R12]
            end else if (id == st_reg.dynId[PTR_GP2] || id == st_reg.dynId[PTR_GP4]) begin
                adr = byteOf(d, 2);
                hit = !adr[7] || addrHit(adr[6:0], ownAddr, d[6:0]); // [R7] [R24]
                if (hit) begin
                    n.cmd = mkCmd(d[6:0], (id == st_reg.dynId[PTR_GP2]) ? PTR_GP2 : PTR_GP4,
                                  {16'h0000, d[31:16], 16'h0000}); // [R6]
                end
            end else if (isApp) begin
                // node bound identifiers live only in the owning node's table
                for (int p = PTR_APP_FIRST; p <= PTR_APP_LAST; p++) begin
                    if (id == st_reg.dynId[p]) begin
                        n.cmd = mkCmd(7'h00, p, d[47:0]); // [R8] [R9]
                    end
                end
            end else if (id == st_reg.dynId[PTR_PREP] && !frameIn.pid[5]) begin // [R21]
                cmd = byteOf(d, 1);
                adr = byteOf(d, 2);
                if (cmd[7] && adr[7]) begin
                    n.prep = PREP_HELD; // [R18] [R17]
                    n.prepCmd = cmd[6:0];
                    n.prepMatch = addrHit(adr[6:0], ownAddr, MASK_FULL);
                end
            end
        end

        // a header opens the next frame: answer, then drop the preparation
        if (hdrValid && st_reg.enable) begin
            id = hdrPid[5:0];
            if (hdrPid != protect(id)) begin
                parEvt = 1'b1;
                n.parErr = 1'b1; // [R22]
            end else if (id == ID_READ) begin
                if (n.prep == PREP_HELD && n.prepMatch) begin
                    n.resp.valid = 1'b1; // [R13] [R16] [R11]
                    n.resp.cmd = n.prepCmd;
                end
            end else if (id == st_reg.dynId[PTR_GET_POS]) begin
                n.resp.valid = 1'b1; // [R15] [R12]
                n.resp.cmd = CMD_GET_POS;
            end else if (id == st_reg.dynId[PTR_GET_STATUS]) begin
                n.resp.valid = 1'b1; // [R15] [R12]
                n.resp.cmd = CMD_GET_STATUS;
            end
            n.resp.addr = ownAddr; // [R14]
            if (!(frameValid && n.prep == PREP_HELD && st_reg.prep == PREP_IDLE)) begin
                n.prep = PREP_IDLE; // [R24]
                n.prepMatch = 1'b0;
            end
        end

        // apb: data is latched in setup; the access phase waits only while clkEn is low
        case (apbReq.paddr)
            REG_CTRL: rd[CTRL_ENABLE_BIT] = st_reg.enable;
            REG_ID_A: begin
                for (int p = 0; p < 4; p++) begin
                    rd[ID_STRIDE*p +: 6] = st_reg.dynId[p];
                end
            end
            REG_ID_B: begin
                for (int p = 0; p < 4; p++) begin
                    rd[ID_STRIDE*p +: 6] = st_reg.dynId[p+4];
                end
            end
            REG_ID_C: rd[5:0] = st_reg.dynId[PTR_PREP];
            REG_STATUS: begin
                rd[ST_ADDR_LSB +: 7] = ownAddr;
                rd[ST_PREP_BIT] = st_reg.prep == PREP_HELD;
                rd[ST_MATCH_BIT] = st_reg.prepMatch;
                rd[ST_PARERR_BIT] = st_reg.parErr;
                rd[ST_CMD_LSB +: 7] = st_reg.prepCmd;
            end
            default: rd = 32'h0000_0000;
        endcase
        if (apbReq.psel && !apbReq.penable) begin
            n.rdata = apbReq.pwrite ? 32'h0000_0000 : rd;
            n.slvErr = !(apbReq.paddr inside {REG_CTRL, REG_ID_A, REG_ID_B, REG_ID_C,
                                              REG_STATUS});
        end
        if (apbReq.psel && apbReq.penable && apbReq.pwrite && !st_reg.slvErr) begin
            case (apbReq.paddr)
                REG_CTRL: begin
                    n.enable = apbReq.pwdata[CTRL_ENABLE_BIT];
                    // a parity event in the same cycle wins over the clear
                    if (apbReq.pwdata[CTRL_CLR_PARERR_BIT] && !parEvt) begin
                        n.parErr = 1'b0;
                    end
                end
                REG_ID_A: begin
                    for (int p = 0; p < 4; p++) begin
                        n.dynId[p] = apbReq.pwdata[ID_STRIDE*p +: 6];
                    end
                end
                REG_ID_B: begin
                    for (int p = 0; p < 4; p++) begin
                        n.dynId[p+4] = apbReq.pwdata[ID_STRIDE*p +: 6];
                    end
                end
                REG_ID_C: n.dynId[PTR_PREP] = apbReq.pwdata[5:0];
                default: n.enable = n.enable;
            endcase
        end

        st_next = clkEn ? n : st_reg;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.enable <= CTRL_ENABLE_RESET;
            for (int p = 0; p < NUM_PTR; p++) begin
                st_reg.dynId[p] <= DYNID_RESET;
            end
            st_reg.prep <= PREP_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.rdata;
    assign pslverr = st_reg.slvErr && apbReq.psel && apbReq.penable;
    assign pready = clkEn;
    assign cmdOut = st_reg.cmd;
    assign sleepReq = st_reg.sleep;
    assign respOut = st_reg.resp;
    assign nodeAddr = ownAddr;

endmodule : lsa_frame_addressing

// [lsa_pkg.sv]
// lsa_pkg: constants and carrier types of the frame addressing block
package lsa_pkg;
    localparam logic [5:0] ID_CMD = 6'h3c;
    localparam logic [5:0] ID_READ = 6'h3d;
    localparam logic [5:0] ID_EXTENDED = 6'h3f;
    localparam logic [7:0] BYTE_SLEEP = 8'h00;
    localparam logic [7:0] BYTE_EXT = 8'h80;
    localparam logic [6:0] CMD_GET_POS = 7'h00;
    localparam logic [6:0] CMD_GET_STATUS = 7'h03;
    localparam logic [6:0] CMD_READ_LAST = 7'h03;
    localparam logic [6:0] CMD_SHORT_FIRST = 7'h0c;
    localparam logic [6:0] CMD_SHORT_LAST = 7'h0e;
    localparam logic [6:0] MASK_SHORT = 7'h0f;
    localparam logic [6:0] MASK_FULL = 7'h7f;
    localparam logic [3:0] LEN_2 = 4'h2;
    localparam logic [3:0] LEN_4 = 4'h4;
    localparam logic [3:0] LEN_8 = 4'h8;
    localparam int NUM_PTR = 9;
    localparam int PTR_GP2 = 0;
    localparam int PTR_GP4 = 1;
    localparam int PTR_GET_POS = 2;
    localparam int PTR_GET_STATUS = 3;
    localparam int PTR_APP_FIRST = 4;
    localparam int PTR_APP_LAST = 7;
    localparam int PTR_PREP = 8;
    localparam logic [5:0] DYNID_RESET = 6'h3f;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ID_A = 8'h04;
    localparam logic [7:0] REG_ID_B = 8'h08;
    localparam logic [7:0] REG_ID_C = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLR_PARERR_BIT = 1;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int ID_STRIDE = 8;
    localparam int ST_ADDR_LSB = 0;
    localparam int ST_PREP_BIT = 8;
    localparam int ST_MATCH_BIT = 9;
    localparam int ST_PARERR_BIT = 10;
    localparam int ST_CMD_LSB = 16;
    // per address bit a 3-bit index into {programmed, strap}
    localparam logic [20:0] MAP_SEL0 = {3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    localparam logic [20:0] MAP_SEL1 = {3'h2, 3'h1, 3'h0, 3'h6, 3'h5, 3'h4, 3'h3};

    typedef enum logic {
        PREP_IDLE = 1'b0,
        PREP_HELD = 1'b1
    } lsa_prep_type;

    typedef struct packed {
        logic [7:0] pid;
        logic [63:0] data;
    } lsa_frame_type;

    typedef struct packed {
        logic valid;
        logic [6:0] code;
        logic [3:0] ptr;
        logic [47:0] params;
    } lsa_cmd_type;

    typedef struct packed {
        logic valid;
        logic [6:0] cmd;
        logic [6:0] addr;
    } lsa_resp_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } lsa_apb_type;
endpackage : lsa_pkg

// [lsa_frame_addressing_properties.sv]
// lsa_frame_addressing_properties: port-level checks of addressing and answers
`timescale 1ns/100ps
module lsa_frame_addressing_properties
    import lsa_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [3:0] programmed_address_bits,
    input wire logic address_mapping_select,
    input wire logic [2:0] strap_address_bits,
    input wire logic hdrValid,
    input wire logic [7:0] hdrPid,
    input wire logic frameValid,
    input wire lsa_frame_type frameIn,
    input wire lsa_cmd_type cmdOut,
    input wire logic sleepReq,
    input wire lsa_resp_type respOut,
    input wire logic [6:0] nodeAddr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic [2:0] strapLast_reg;
    logic [3:0] quiet_reg;

    // straps pass a synchroniser, so the address is only judged once they sat still
    always_ff @(posedge core_clk) begin
        strapLast_reg <= strap_address_bits;
        if (sys_rst || !clkEn || strap_address_bits != strapLast_reg) quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
    end

    function automatic logic [1:0] par2(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
    endfunction : par2

    property p_addr_map;
        quiet_reg >= 4'h6 |-> nodeAddr == (address_mapping_select ?
            {strap_address_bits, programmed_address_bits} :
            {programmed_address_bits, strap_address_bits});
    endproperty
    a_addr_map: assert property (p_addr_map)
        else $error("node address differs from mapped bits");
    property p_cmd_cause;
        cmdOut.valid |-> $past(frameValid && clkEn);
    endproperty
    a_cmd_cause: assert property (p_cmd_cause)
        else $error("command issued without a frame");
    property p_sleep;
        sleepReq |-> $past(frameValid) && $past(frameIn.pid[5:0]) == ID_CMD
            && $past(frameIn.data[7:0]) == BYTE_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep request without a sleep frame");
    property p_sleep_excl;
        sleepReq |-> !cmdOut.valid;
    endproperty
    a_sleep_excl: assert property (p_sleep_excl)
        else $error("sleep frame also issued a command");
    property p_resp_addr;
        respOut.valid |-> respOut.addr == nodeAddr;
    endproperty
    a_resp_addr: assert property (p_resp_addr)
        else $error("answer lacks own address");
    property p_resp_hdr;
        respOut.valid |-> $past(hdrValid && clkEn);
    endproperty
    a_resp_hdr: assert property (p_resp_hdr)
        else $error("answer without a header");
    property p_hdr_parity;
        hdrValid && !frameValid && hdrPid[7:6] != par2(hdrPid[5:0]) |=> !respOut.valid;
    endproperty
    a_hdr_parity: assert property (p_hdr_parity)
        else $error("answered a header with bad parity");
    property p_frame_parity;
        frameValid && frameIn.pid[7:6] != par2(frameIn.pid[5:0]) |=> !cmdOut.valid && !sleepReq;
    endproperty
    a_frame_parity: assert property (p_frame_parity)
        else $error("acted on a frame with bad parity");

    c_cmd: cover property (cmdOut.valid);
    c_resp: cover property (respOut.valid);
    c_sleep: cover property (sleepReq);
endmodule : lsa_frame_addressing_properties

// [lsa_lin_master.sv]
// lsa_lin_master: behavioural bus master issuing header and frame pulses
`timescale 1ns/100ps
module lsa_lin_master
    import lsa_pkg::*;
(
    input wire logic core_clk,
    output logic hdrValid,
    output logic [7:0] hdrPid,
    output logic frameValid,
    output lsa_frame_type frameIn
);
    initial begin
        hdrValid = 1'b0;
        hdrPid = 8'h00;
        frameValid = 1'b0;
        frameIn = '0;
    end

    // six id bits under two parity bits
    function automatic logic [7:0] protect(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction : protect

    // caller stands just past an edge; bad flips a parity bit on purpose
    task automatic send_header(input logic [5:0] id, input logic bad);
        hdrValid <= 1'b1;
        hdrPid <= protect(id) ^ {bad, 7'h00};
        @(posedge core_clk);
        hdrValid <= 1'b0;
        hdrPid <= ~hdrPid;
    endtask : send_header

    // header first, data later; lines carry junk once released
    task automatic send_frame(input logic [5:0] id, input logic [63:0] d,
                              input logic bad = 1'b0);
        send_header(id, 1'b0);
        repeat (2) @(posedge core_clk);
        frameValid <= 1'b1;
        frameIn <= '{pid: protect(id) ^ {bad, 7'h00}, data: d};
        @(posedge core_clk);
        frameValid <= 1'b0;
        frameIn <= ~frameIn;
    endtask : send_frame
endmodule : lsa_lin_master

// [lsa_frame_addressing_tb_top.sv]
// lsa_frame_addressing_tb_top: self-checking bench of the addressing block
`timescale 1ns/100ps
module lsa_frame_addressing_tb_top
    import lsa_pkg::*;
;
    logic core_clk, sys_rst, clkEn, addrSel, hdrValid, frameValid, pready, pslverr, sleepReq, err;
    lsa_apb_type apbReq;
    lsa_frame_type frameIn;
    lsa_cmd_type cmdOut;
    lsa_resp_type respOut;
    logic [31:0] prdata, rd;
    logic [3:0] progBits, lastPtr;
    logic [47:0] lastPar;
    logic [2:0] strapBits;
    logic [7:0] hdrPid;
    logic [6:0] nodeAddr, own, lastCode, lastRespCmd, lastRespAddr;
    int n_fail, tests_run, nCmd, nResp, nSleep, c0, r0, s0;

    lsa_frame_addressing uut (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .programmed_address_bits(progBits), .address_mapping_select(addrSel),
        .strap_address_bits(strapBits), .hdrValid(hdrValid), .hdrPid(hdrPid),
        .frameValid(frameValid), .frameIn(frameIn), .cmdOut(cmdOut), .sleepReq(sleepReq),
        .respOut(respOut), .nodeAddr(nodeAddr));
    lsa_lin_master lm (.core_clk(core_clk), .hdrValid(hdrValid), .hdrPid(hdrPid),
        .frameValid(frameValid), .frameIn(frameIn));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // pulses are counted, so a second or a missing pulse both show
    always @(posedge core_clk) begin
        if (cmdOut.valid === 1'b1) begin
            nCmd++;
            lastCode = cmdOut.code;
            lastPtr = cmdOut.ptr;
            lastPar = cmdOut.params;
        end
        if (sleepReq === 1'b1) nSleep++;
        if (respOut.valid === 1'b1) begin
            nResp++;
            lastRespCmd = respOut.cmd;
            lastRespAddr = respOut.addr;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        // only the watchdog ends a stuck access
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        apbReq <= '0;
        @(posedge core_clk);
    endtask : apb

    task automatic frame(input logic [5:0] id, input logic [63:0] d, input int nc, input int ns);
        c0 = nCmd;
        s0 = nSleep;
        lm.send_frame(id, d);
        repeat (3) @(posedge core_clk);
        chk(32'(nCmd - c0), 32'(nc));
        chk(32'(nSleep - s0), 32'(ns));
    endtask : frame

    task automatic hdr(input logic [5:0] id, input logic bad, input int nr, input logic [6:0] cmd);
        r0 = nResp;
        lm.send_header(id, bad);
        repeat (3) @(posedge core_clk);
        chk(32'(nResp - r0), 32'(nr));
        if (nr > 0) begin
            chk(32'(lastRespCmd), 32'(cmd));
            chk(32'(lastRespAddr), 32'(own));
        end
    endtask : hdr

    // short position codes compare only the low four address bits
    function automatic int expHit(input logic [6:0] a, input logic [6:0] c);
        if (c >= CMD_SHORT_FIRST && c <= CMD_SHORT_LAST) begin
            return int'(a[3:0] == own[3:0]);
        end
        return int'(a == own);
    endfunction : expHit

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        logic [6:0] a, c;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        apbReq = '0;
        rd = $urandom(17);
        progBits = 4'($urandom);
        strapBits = 3'($urandom);
        addrSel = 1'($urandom);
        own = addrSel ? {strapBits, progBits} : {progBits, strapBits};
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk(32'(nodeAddr), 32'(own));
        // ids: gp2 0x18, gp4 0x28, direct position read 0x21, direct status 0x03, prep 0x1a
        apb(1'b1, REG_ID_A, 32'h0321_2818, rd, err);
        apb(1'b1, REG_ID_C, 32'h0000_001a, rd, err);
        apb(1'b1, REG_ID_B, 32'h3f3f_3f10, rd, err);
        apb(1'b0, REG_ID_A, 32'h0, rd, err);
        chk(rd, 32'h0321_2818);
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        chk(rd & 32'h7f, 32'(own));
        apb(1'b0, 8'h40, 32'h0, rd, err);
        chk(32'(err), 32'h1);
        frame(6'h18, {48'h0, 1'b1, own, 8'h2a}, 1, 0);
        chk(32'(lastCode), 32'h2a);
        frame(6'h18, {48'h0, 1'b1, own ^ 7'h40, 8'h2a}, 0, 0);
        frame(6'h28, {32'h0, 16'h1234, 1'b0, ~own, 8'h15}, 1, 0);
        chk(32'(lastPtr), PTR_GP4);
        chk(32'(lastPar[31:16]), 32'h1234);
        frame(6'h10, 64'hffff_ffff_ffff_5a5a, 1, 0);
        chk(32'(lastPtr), PTR_APP_FIRST);
        chk(32'(lastCode), 32'h0);
        chk(32'(lastPar[47:16]), 32'h0);
        chk(32'(lastPar[15:0]), 32'h5a5a);
        frame(ID_CMD, 64'h0, 0, 1);
        frame(ID_CMD, {40'h0, 1'b1, ~own[6:4], own[3:0], 8'h0c, BYTE_EXT}, 1, 0);
        chk(32'(lastCode), 32'h0c);
        frame(ID_CMD, {40'h0, 1'b1, ~own[6:4], own[3:0], 8'h0b, BYTE_EXT}, 0, 0);
        frame(ID_CMD, {40'h0, 1'b1, own, 8'h0b, BYTE_EXT}, 1, 0);
        frame(ID_CMD, {40'h0, 1'b1, own, 8'h0b, 8'h7f}, 0, 0);
        frame(6'h21, {40'h0, 1'b1, own, 8'h05, 8'h00}, 0, 0);
        frame(ID_EXTENDED, {40'h0, 1'b1, own, 8'h0b, BYTE_EXT}, 0, 0);
        frame(6'h1a, {48'h0, 1'b1, own, 1'b1, CMD_GET_STATUS}, 0, 0);
        hdr(ID_READ, 1'b0, 1, CMD_GET_STATUS);
        hdr(ID_READ, 1'b0, 0, 7'h00);
        frame(6'h1a, {48'h0, 1'b1, ~own, 1'b1, CMD_GET_STATUS}, 0, 0);
        hdr(ID_READ, 1'b0, 0, 7'h00);
        frame(ID_CMD, {40'h0, 1'b1, own, 1'b1, CMD_GET_POS, BYTE_EXT}, 0, 0);
        hdr(ID_READ, 1'b0, 1, CMD_GET_POS);
        hdr(6'h21, 1'b0, 1, CMD_GET_POS);
        hdr(6'h03, 1'b0, 1, CMD_GET_STATUS);
        hdr(6'h21, 1'b1, 0, 7'h00);
        c0 = nCmd;
        s0 = nSleep;
        lm.send_frame(ID_CMD, 64'h0, 1'b1);
        repeat (3) @(posedge core_clk);
        chk(32'(nCmd - c0), 32'h0);
        chk(32'(nSleep - s0), 32'h0);
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        chk(32'(rd[ST_PARERR_BIT]), 32'h1);
        apb(1'b1, REG_CTRL, 32'h0000_0003, rd, err);
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        chk(32'(rd[ST_PARERR_BIT]), 32'h0);
        for (int i = 0; i < 20; i++) begin
            a = ($urandom % 2) ? own : 7'($urandom);
            c = 7'($urandom);
            frame(6'h18, {48'h0, 1'b1, a, 1'b0, c}, expHit(a, c), 0);
        end
        wrap_up();
    end
endmodule : lsa_frame_addressing_tb_top

bind lsa_frame_addressing lsa_frame_addressing_properties chk_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .clkEn(clkEn), .programmed_address_bits(programmed_address_bits),
    .address_mapping_select(address_mapping_select), .strap_address_bits(strap_address_bits),
    .hdrValid(hdrValid), .hdrPid(hdrPid), .frameValid(frameValid), .frameIn(frameIn),
    .cmdOut(cmdOut), .sleepReq(sleepReq), .respOut(respOut), .nodeAddr(nodeAddr));
